// ---- rtl/bec_pkg.sv ----
package bec_pkg;
  localparam int BEC_EVENTS = 8;
  localparam int BEC_ADDR_W = 24;
  localparam int BEC_DATA_W = 16;
  localparam int BEC_CNT_W = 8;
  localparam logic [7:0] BEC_PASS_MIN = 8'h01;
  localparam logic [15:0] BEC_MASK_ODD = 16'hFF00;
  localparam logic [15:0] BEC_MASK_EVEN = 16'h00FF;
  localparam logic [15:0] BEC_MASK_WORD = 16'hFFFF;
  localparam int BEC_ST_W = 2;
  localparam logic [1:0] BEC_ST_RESET = 2'h0;

  typedef enum logic [1:0] {
    BEC_MODE_AND = 2'b00,
    BEC_MODE_AND_SAME = 2'b01,
    BEC_MODE_OR = 2'b10,
    BEC_MODE_STATE = 2'b11
  } bec_mode_type;

  typedef enum logic [1:0] {
    BEC_ACC_READ = 2'b01,
    BEC_ACC_WRITE = 2'b10,
    BEC_ACC_BOTH = 2'b11
  } bec_acc_type;
endpackage

// ---- rtl/bec_hit_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bec_hit_if;
  logic hit;
  logic pass_done;
  modport det (output hit, output pass_done);
  modport comb (input hit, input pass_done);
endinterface
`default_nettype wire

// ---- rtl/bec_detector.sv ----
`timescale 1ns/1ps
`default_nettype none
module bec_detector
  import bec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic force_one,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_byte,
  input wire logic [BEC_ADDR_W-1:0] cyc_addr,
  input wire logic [BEC_DATA_W-1:0] cyc_data,
  input wire logic [BEC_ADDR_W-1:0] ev_addr,
  input wire logic [BEC_DATA_W-1:0] ev_data,
  input wire logic [BEC_DATA_W-1:0] ev_mask,
  input wire logic ev_data_en,
  input wire bec_acc_type ev_acc,
  input wire logic [BEC_CNT_W-1:0] ev_pass,
  bec_hit_if.det hif
);
  logic [BEC_CNT_W-1:0] cnt_reg;
  logic [BEC_DATA_W-1:0] lane_mask;
  logic acc_ok;
  logic match;
  logic [BEC_CNT_W-1:0] target;

  always_comb begin
    // Byte cycles compare only the lane that carries the byte
    if (cyc_byte) begin
      lane_mask = cyc_addr[0] ? BEC_MASK_ODD : BEC_MASK_EVEN;
    end else begin
      lane_mask = BEC_MASK_WORD;
    end
  end

  assign acc_ok = cyc_write ? ev_acc[1] : ev_acc[0];
  assign match = cyc_valid && acc_ok && (cyc_addr == ev_addr) &&
    (!ev_data_en || (((cyc_data ^ ev_data) & ev_mask & lane_mask) == '0));
  assign target = (force_one || ev_pass == '0) ? BEC_PASS_MIN : ev_pass;
  assign hif.hit = match;
  assign hif.pass_done = (cnt_reg >= target);

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      cnt_reg <= '0;
    end else if (match && cnt_reg < target) begin
      cnt_reg <= cnt_reg + BEC_PASS_MIN;
    end
  end

  a_read_only: assert property (@(posedge clk) disable iff (rst)
    (cyc_valid && cyc_write && ev_acc == BEC_ACC_READ) |-> !match)
    else $error("read-only event hit a write");
  a_write_only: assert property (@(posedge clk) disable iff (rst)
    (cyc_valid && !cyc_write && ev_acc == BEC_ACC_WRITE) |-> !match)
    else $error("write-only event hit a read");
  a_lane_odd: assert property (@(posedge clk) disable iff (rst)
    (cyc_valid && cyc_byte && cyc_addr[0] && ev_data_en && ev_mask[15:8] == 8'hFF &&
     cyc_data[15:8] != ev_data[15:8]) |-> !match)
    else $error("odd byte lane not compared");
  a_lane_even: assert property (@(posedge clk) disable iff (rst)
    (cyc_valid && cyc_byte && !cyc_addr[0] && cyc_addr == ev_addr &&
     (ev_acc == BEC_ACC_BOTH || (cyc_write && ev_acc == BEC_ACC_WRITE)) &&
     cyc_data[7:0] == ev_data[7:0]) |-> match)
    else $error("even byte lane miscompared");
  a_count_hold: assert property (@(posedge clk) disable iff (rst)
    (!clear && (!match || hif.pass_done)) |=> $stable(cnt_reg))
    else $error("pass counter moved");
endmodule
`default_nettype wire

// ---- rtl/bec_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bec_top
  import bec_pkg::*;
#(
  parameter int EVENTS = BEC_EVENTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_byte,
  input wire logic [BEC_ADDR_W-1:0] cyc_addr,
  input wire logic [BEC_DATA_W-1:0] cyc_data,
  input wire bec_mode_type mode,
  input wire logic [EVENTS-1:0] ev_enable,
  input wire logic [EVENTS*BEC_ADDR_W-1:0] ev_addr,
  input wire logic [EVENTS*BEC_DATA_W-1:0] ev_data,
  input wire logic [EVENTS*BEC_DATA_W-1:0] ev_mask,
  input wire logic [EVENTS-1:0] ev_data_en,
  input wire logic [EVENTS*2-1:0] ev_acc,
  input wire logic [EVENTS*BEC_CNT_W-1:0] ev_pass,
  input wire logic [EVENTS*BEC_ST_W-1:0] st_next,
  input wire logic [BEC_ST_W-1:0] st_break,
  input wire logic break_clear,
  output logic break_req,
  output logic [EVENTS-1:0] ev_status,
  output logic [BEC_ST_W-1:0] st_state
);
  logic [EVENTS-1:0] hit;
  logic [EVENTS-1:0] done;
  logic force_one;
  logic cond;
  logic [BEC_ST_W-1:0] st_next_val;
  logic st_adv;

  assign force_one = (mode == BEC_MODE_AND_SAME);

  genvar i;
  generate
    for (i = 0; i < EVENTS; i++) begin : g_det
      bec_hit_if hif ();
      bec_detector u_det (
        .clk(clk),
        .rst(rst),
        .clear(break_clear),
        .force_one(force_one),
        .cyc_valid(cyc_valid),
        .cyc_write(cyc_write),
        .cyc_byte(cyc_byte),
        .cyc_addr(cyc_addr),
        .cyc_data(cyc_data),
        .ev_addr(ev_addr[i*BEC_ADDR_W +: BEC_ADDR_W]),
        .ev_data(ev_data[i*BEC_DATA_W +: BEC_DATA_W]),
        .ev_mask(ev_mask[i*BEC_DATA_W +: BEC_DATA_W]),
        .ev_data_en(ev_data_en[i]),
        .ev_acc(bec_acc_type'(ev_acc[i*2 +: 2])),
        .ev_pass(ev_pass[i*BEC_CNT_W +: BEC_CNT_W]),
        .hif(hif)
      );
      assign hit[i] = hif.hit;
      assign done[i] = hif.pass_done;
    end
  endgenerate

  // Lowest enabled event on its first hit, pass count one, steers the state
  always_comb begin
    st_adv = 1'b0;
    st_next_val = st_state;
    for (int k = EVENTS - 1; k >= 0; k--) begin
      if (ev_enable[k] && hit[k] && done[k] == 1'b0 &&
          (ev_pass[k*BEC_CNT_W +: BEC_CNT_W] <= BEC_PASS_MIN)) begin
        st_adv = 1'b1;
        st_next_val = st_next[k*BEC_ST_W +: BEC_ST_W];
      end
    end
  end

  always_comb begin
    case (mode)
      BEC_MODE_AND: cond = (ev_enable != '0) && ((done & ev_enable) == ev_enable);
      BEC_MODE_AND_SAME: cond = (ev_enable != '0) && ((hit & ev_enable) == ev_enable);
      BEC_MODE_OR: cond = |(done & ev_enable);
      BEC_MODE_STATE: cond = (st_state == st_break);
      default: cond = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || break_clear) begin
      st_state <= BEC_ST_RESET;
    end else if (mode == BEC_MODE_STATE && st_adv) begin
      st_state <= st_next_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || break_clear) begin
      break_req <= 1'b0;
    end else if (cond) begin
      break_req <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_status <= '0;
    end else begin
      ev_status <= done & ev_enable;
    end
  end

  // Named steps of the break conditions
  sequence s_all_done;
    mode == BEC_MODE_AND && !break_clear && ev_enable != '0 &&
      (done & ev_enable) == ev_enable;
  endsequence

  sequence s_none_enabled;
    (mode == BEC_MODE_AND || mode == BEC_MODE_AND_SAME) && ev_enable == '0 &&
      !break_req;
  endsequence

  sequence s_low_step;
    mode == BEC_MODE_STATE && !break_clear && ev_enable[0] && hit[0] && !done[0] &&
      (ev_pass[BEC_CNT_W-1:0] <= BEC_PASS_MIN);
  endsequence

  sequence s_same_partial;
    mode == BEC_MODE_AND_SAME && !break_req && ev_enable != '0 &&
      (hit & ev_enable) != ev_enable;
  endsequence

  sequence s_or_idle;
    mode == BEC_MODE_OR && !break_req && (done & ev_enable) == '0;
  endsequence

  property p_and_break;
    @(posedge clk) disable iff (rst)
      s_all_done |=> break_req;
  endproperty

  property p_empty_quiet;
    @(posedge clk) disable iff (rst)
      s_none_enabled |=> !break_req;
  endproperty

  property p_state_low;
    @(posedge clk) disable iff (rst)
      s_low_step |=> st_state == $past(st_next[BEC_ST_W-1:0]);
  endproperty

  property p_same_partial;
    @(posedge clk) disable iff (rst)
      s_same_partial |=> !break_req;
  endproperty

  property p_or_idle;
    @(posedge clk) disable iff (rst)
      s_or_idle |=> !break_req;
  endproperty

  a_same_break: assert property (@(posedge clk) disable iff (rst)
    (mode == BEC_MODE_AND_SAME && !break_clear && ev_enable != '0 &&
     (hit & ev_enable) == ev_enable) |=> break_req)
    else $error("same-time hit did not break");
  a_and_wait: assert property (@(posedge clk) disable iff (rst)
    (mode == BEC_MODE_AND && !break_req && !cond) |=> !break_req)
    else $error("and mode broke early");
  a_or_break: assert property (@(posedge clk) disable iff (rst)
    (mode == BEC_MODE_OR && !break_clear && |(done & ev_enable)) |=> break_req)
    else $error("or mode missed break");
  a_state_break: assert property (@(posedge clk) disable iff (rst)
    (mode == BEC_MODE_STATE && !break_clear && st_state == st_break) |=> break_req)
    else $error("break state missed");
  a_break_sticky: assert property (@(posedge clk) disable iff (rst)
    (break_req && !break_clear) |=> break_req)
    else $error("break dropped");
  a_force_one: assert property (@(posedge clk) disable iff (rst)
    (mode == BEC_MODE_AND_SAME && !break_clear && hit[0]) |=> done[0])
    else $error("pass count not forced");
  a_status_done: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> ev_status == $past(done & ev_enable))
    else $error("status mismatch");
  a_clear_drop: assert property (@(posedge clk) disable iff (rst)
    break_clear |=> !break_req && st_state == BEC_ST_RESET)
    else $error("clear ignored");
  a_and_break: assert property (p_and_break)
    else $error("and mode missed break");
  a_empty_quiet: assert property (p_empty_quiet)
    else $error("empty enable broke");
  a_state_low: assert property (p_state_low)
    else $error("lowest event did not steer state");
  a_same_need_all: assert property (p_same_partial)
    else $error("same-time break without all hits");
  a_or_quiet: assert property (p_or_idle)
    else $error("or mode broke early");
  a_state_hold: assert property (@(posedge clk) disable iff (rst)
    (mode != BEC_MODE_STATE && !break_clear) |=> $stable(st_state))
    else $error("state moved outside state mode");
  a_status_enable: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (ev_status & ~$past(ev_enable)) == '0)
    else $error("status set for disabled event");
  a_reset_idle: assert property (@(posedge clk) rst |=>
    !break_req && ev_status == '0 && st_state == BEC_ST_RESET)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ---- tb/bec_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bec_cpu_model
  import bec_pkg::*;
(
  input wire logic clk,
  output logic v,
  output logic w,
  output logic b,
  output logic [BEC_ADDR_W-1:0] a,
  output logic [BEC_DATA_W-1:0] d
);
  initial begin
    v = 1'b0;
    w = 1'b0;
    b = 1'b0;
    a = 24'h000000;
    d = 16'h0000;
  end
  // One bus cycle; on release, address and data show the inverse
  task automatic cyc(input logic wr, input logic by, input logic [23:0] ad,
                     input logic [15:0] dt);
    @(posedge clk);
    v <= 1'b1;
    w <= wr;
    b <= by;
    a <= ad;
    d <= dt;
    @(posedge clk);
    v <= 1'b0;
    a <= ~ad;
    d <= ~dt;
  endtask
endmodule
`default_nettype wire

// ---- tb/bec_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bec_top_tb
  import bec_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  bec_mode_type mode = BEC_MODE_AND;
  logic [7:0] en = 8'h00;
  logic [7:0] den = 8'h00;
  logic [7:0][23:0] ea = '0;
  logic [7:0][15:0] ed = '0;
  logic [7:0][15:0] em = '0;
  logic [7:0][1:0] ac = '0;
  logic [7:0][7:0] ps = '0;
  logic [7:0][1:0] nx = '0;
  logic [1:0] sb = 2'h0;
  logic v, w, b, brk;
  logic [23:0] a;
  logic [15:0] d;
  logic [7:0] sts;
  logic [1:0] st;
  int fails = 0;
  int tests_run = 0;
  initial forever #2.5 clk = ~clk;
  bec_cpu_model cpu (.clk(clk), .v(v), .w(w), .b(b), .a(a), .d(d));
  bec_top dut (.clk(clk), .rst(rst), .cyc_valid(v), .cyc_write(w),
    .cyc_byte(b), .cyc_addr(a), .cyc_data(d), .mode(mode), .ev_enable(en),
    .ev_addr(ea), .ev_data(ed), .ev_mask(em), .ev_data_en(den), .ev_acc(ac),
    .ev_pass(ps), .st_next(nx), .st_break(sb), .break_clear(clr),
    .break_req(brk), .ev_status(sts), .st_state(st));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ev(input int k, input logic [23:0] ad, input logic [15:0] dt,
    input logic [15:0] mk, input logic [1:0] c, input logic [7:0] p, input logic [1:0] n);
    @(posedge clk);
    en[k] <= 1'b1;
    ea[k] <= ad;
    ed[k] <= dt;
    em[k] <= mk;
    den[k] <= (mk != 16'h0000);
    ac[k] <= c;
    ps[k] <= p;
    nx[k] <= n;
  endtask
  task automatic rs(input bec_mode_type m);
    @(posedge clk);
    clr <= 1'b1;
    en <= 8'h00;
    mode <= m;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic look(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, brk}, {7'h00, e});
  endtask
  task automatic t_and();
    rs(BEC_MODE_AND);
    ev(0, 24'h000512, 16'h0000, 16'h0000, BEC_ACC_WRITE, 8'h02, 2'h0);
    ev(1, 24'h000600, 16'h0000, 16'h0000, BEC_ACC_READ, 8'h01, 2'h0);
    cpu.cyc(1'b1, 1'b0, 24'h000512, 16'h0000);
    cpu.cyc(1'b0, 1'b0, 24'h000600, 16'h0000);
    cpu.cyc(1'b0, 1'b0, 24'h000512, 16'h0000);
    look(1'b0);
    chk(sts, 8'h02);
    cpu.cyc(1'b1, 1'b0, 24'h000512, 16'h0000);
    look(1'b1);
  endtask
  task automatic t_or();
    rs(BEC_MODE_OR);
    ev(0, 24'h000512, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h03, 2'h0);
    ev(1, 24'h000700, 16'h0000, 16'h0000, BEC_ACC_WRITE, 8'h01, 2'h0);
    cpu.cyc(1'b1, 1'b0, 24'h000512, 16'h0000);
    cpu.cyc(1'b0, 1'b0, 24'h000512, 16'h0000);
    look(1'b0);
    cpu.cyc(1'b0, 1'b0, 24'h000512, 16'h0000);
    look(1'b1);
  endtask
  task automatic t_same();
    rs(BEC_MODE_AND_SAME);
    ev(0, 24'h000800, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h05, 2'h0);
    ev(1, 24'h000800, 16'h1234, 16'hFFFF, BEC_ACC_WRITE, 8'h05, 2'h0);
    cpu.cyc(1'b0, 1'b0, 24'h000800, 16'h1234);
    look(1'b0);
    chk(sts, 8'h01);
    cpu.cyc(1'b1, 1'b0, 24'h000800, 16'h1234);
    look(1'b1);
    chk(sts, 8'h03);
  endtask
  task automatic t_lane();
    rs(BEC_MODE_AND);
    ev(0, 24'h000519, 16'h0300, 16'hFF00, BEC_ACC_WRITE, 8'h01, 2'h0);
    ev(1, 24'h00051A, 16'h0002, 16'h00FF, BEC_ACC_WRITE, 8'h01, 2'h0);
    cpu.cyc(1'b1, 1'b1, 24'h000519, 16'h1503);
    cpu.cyc(1'b1, 1'b1, 24'h00051A, 16'h5502);
    look(1'b0);
    cpu.cyc(1'b1, 1'b1, 24'h000519, 16'h0315);
    look(1'b1);
  endtask
  task automatic t_state();
    rs(BEC_MODE_STATE);
    sb <= 2'h2;
    ev(0, 24'h000900, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h01, 2'h1);
    ev(7, 24'h000A00, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h01, 2'h2);
    cpu.cyc(1'b0, 1'b0, 24'h000900, 16'h0000);
    look(1'b0);
    chk({6'h00, st}, 8'h01);
    cpu.cyc(1'b1, 1'b0, 24'h000A00, 16'h0000);
    look(1'b1);
  endtask
  task automatic t_prio();
    rs(BEC_MODE_STATE);
    sb <= 2'h3;
    ev(2, 24'h000B00, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h01, 2'h3);
    ev(5, 24'h000B00, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h01, 2'h1);
    ev(6, 24'h000C00, 16'h0000, 16'h0000, BEC_ACC_BOTH, 8'h02, 2'h2);
    cpu.cyc(1'b0, 1'b0, 24'h000C00, 16'h0000);
    look(1'b0);
    chk({6'h00, st}, 8'h00);
    cpu.cyc(1'b1, 1'b0, 24'h000B00, 16'h0000);
    look(1'b1);
    chk({6'h00, st}, 8'h03);
  endtask
  task automatic t_rst();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk({7'h00, brk}, 8'h00);
    chk(sts, 8'h00);
    chk({6'h00, st}, 8'h00);
  endtask
  task automatic finish_test();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_and();
    t_or();
    t_same();
    t_lane();
    t_state();
    t_prio();
    t_rst();
    finish_test();
  end
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
